// file: hw/touch_pkg.sv
package touch_pkg;

   localparam int NUM_MODULES = 2;
   localparam int KEYS_PER_MODULE = 4;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL         = 8'h00;
   localparam logic [7:0] OFS_STATUS       = 8'h04;
   localparam logic [7:0] OFS_MODULE_CTRL0 = 8'h08;
   localparam logic [7:0] OFS_MODULE_CTRL1 = 8'h0C;
   localparam logic [7:0] OFS_SLOT_PRESET0 = 8'h10;
   localparam logic [7:0] OFS_SLOT_PRESET1 = 8'h14;
   localparam logic [7:0] OFS_FUNC_COUNT   = 8'h18;
   localparam logic [7:0] OFS_CF_COUNT0    = 8'h1C;
   localparam logic [7:0] OFS_CF_COUNT1    = 8'h20;
   localparam logic [7:0] OFS_SLOT_COUNT   = 8'h24;

   // Control register fields
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_SHARE_BIT = 1;

   // Status register fields
   localparam int ST_SLOT_FLAG_BIT = 0;
   localparam int ST_FUNC_OVF_BIT  = 1;
   localparam int ST_CF_OVF_BIT    = 2;

   // Module control register fields
   localparam int MC_KEY_EN_LSB  = 0;
   localparam int MC_KOEN_BIT    = 4;
   localparam int MC_ROEN_BIT    = 5;
   localparam int MC_TSS_BIT     = 7;
   localparam int MC_KEY_SEL_LSB = 8;

   // Reset values
   localparam logic [1:0]  CTRL_RESET        = 2'h0;
   localparam logic [9:0]  MODULE_CTRL_RESET = 10'h000;
   localparam logic [7:0]  SLOT_PRESET_RESET = 8'h00;

   // Counter terminal values
   localparam logic [4:0]  UNIT_LAST  = 5'h1F;
   localparam logic [7:0]  SLOT_LAST  = 8'hFF;
   localparam logic [15:0] COUNT_LAST = 16'hFFFF;

   // System clock divided by four for the slot clock
   localparam int          SYS_DIV      = 4;
   localparam logic [1:0]  SYS_DIV_LAST = 2'(SYS_DIV - 1);

   typedef struct packed {
      logic [1:0] key_sel;
      logic       tss;
      logic       roen;
      logic       koen;
      logic [3:0] key_en;
   } mod_cfg_t;

   typedef struct packed {
      logic [15:0] cf_count;
      logic [7:0]  slot_count;
      logic        running;
      logic        cf_ovf;
      logic        slot_ovf;
   } mod_stat_t;

endpackage

// file: hw/edge_sync.sv
`timescale 1ns/1ps
module edge_sync #(
   parameter int W = 1
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] rise
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] lvl_q;
   logic [W-1:0] rise_q;
   wire  [W-1:0] agree = ~(s2_q ^ s3_q);
   wire  [W-1:0] lvl_d = (agree & s3_q) | (~agree & lvl_q);

   // Three stages; a level counts once the last two agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q   <= '0;
         s2_q   <= '0;
         s3_q   <= '0;
         lvl_q  <= '0;
         rise_q <= '0;
      end else begin
         s1_q   <= async_in;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         lvl_q  <= lvl_d;
         rise_q <= lvl_d & ~lvl_q;
      end
   end

   assign rise = rise_q;

endmodule

// file: hw/touch_module.sv
`timescale 1ns/1ps
module touch_module (
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  touch_pkg::mod_cfg_t      cfg,
   input  wire logic [3:0]          key_rise,
   input  wire logic                ref_rise,
   input  wire logic                sys4_tick,
   input  wire logic                start_rise,
   input  wire logic                start_lvl,
   input  wire logic                follow,
   input  wire logic                lead_ovf,
   input  wire logic [7:0]          slot_preset,
   output touch_pkg::mod_stat_t     stat
);

   logic [4:0]  unit_q;
   logic [7:0]  slot_q;
   logic [15:0] cf_q;
   logic        run_q;

   wire tick    = cfg.tss ? sys4_tick : ref_rise;
   wire own_ovf = run_q & tick & (unit_q == touch_pkg::UNIT_LAST)
                  & (slot_q == touch_pkg::SLOT_LAST);
   wire end_run = follow ? lead_ovf : own_ovf;
   wire key_hit = key_rise[cfg.key_sel] & cfg.key_en[cfg.key_sel] & cfg.koen;
   wire cf_inc  = run_q & key_hit;
   wire unit_wrap = tick & (unit_q == touch_pkg::UNIT_LAST);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         unit_q <= '0;
         slot_q <= '0;
         cf_q   <= '0;
         run_q  <= 1'b0;
      end else if (start_rise) begin
         unit_q <= '0;
         slot_q <= slot_preset;
         cf_q   <= '0;
         run_q  <= 1'b1;
      end else if (!start_lvl) begin
         unit_q <= '0;
         cf_q   <= '0;
         run_q  <= 1'b0;
      end else if (run_q && end_run) begin
         unit_q <= '0;
         slot_q <= '0;
         run_q  <= 1'b0;
      end else if (run_q) begin
         unit_q <= tick ? unit_q + 5'h01 : unit_q;
         slot_q <= unit_wrap ? slot_q + 8'h01 : slot_q;
         cf_q   <= cf_inc ? cf_q + 16'h0001 : cf_q;
      end
   end

   assign stat.cf_count   = cf_q;
   assign stat.slot_count = slot_q;
   assign stat.running    = run_q;
   assign stat.cf_ovf     = cf_inc & (cf_q == touch_pkg::COUNT_LAST) & ~end_run;
   assign stat.slot_ovf   = own_ovf;

endmodule

// file: hw/touch_key_scan_control.sv
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module touch_key_scan_control (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [2:0]  hburst,
   input  wire logic [3:0]  hprot,
   input  wire logic        hmastlock,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [7:0]  key_osc_in,
   input  wire logic [1:0]  ref_osc_in,
   output logic      [7:0]  key_osc_en,
   output logic      [1:0]  ref_osc_en,
   output logic      [7:0]  key_pad_sel,
   output logic             touch_irq
);

   localparam int NM = touch_pkg::NUM_MODULES;
   localparam int NK = touch_pkg::KEYS_PER_MODULE;

   // Bus address phase capture
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic [31:0] rdata_q;

   // Software registers
   logic [1:0]  ctrl_q;
   logic [9:0]  mctrl_q [NM];
   logic [7:0]  preset_q [NM];

   // Status and counters
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_RUN  = 2'b01,
      PH_DONE = 2'b10
   } phase_t;

   phase_t            phase_q;
   phase_t            phase_d;
   logic              func_ovf_q;
   logic [NM-1:0]     cf_ovf_q;
   logic [15:0]       func_q;
   logic              start_q;
   logic [1:0]        div_q;
   logic              busy_q;
   logic              irq_q;

   touch_pkg::mod_cfg_t  cfg [NM];
   touch_pkg::mod_stat_t stat [NM];

   wire [NM*NK-1:0] key_rise;
   wire [NM-1:0]    ref_rise;

   // Bit 6 of a module control word is not implemented and reads zero
   localparam logic [9:0] MC_IMPL_MASK = 10'h3BF;

   function automatic logic [9:0] mctrl_field(input logic [31:0] d);
      mctrl_field = d[9:0] & MC_IMPL_MASK;
   endfunction

   // Bus decode
   wire addr_phase = hsel & hready & htrans[1];
   wire bus_wr     = addr_phase & hwrite;
   wire [7:0] ofs  = haddr[7:0];
   wire in_range   = (haddr[31:8] == 24'h000000);

   wire wr_ctrl   = wr_pend_q & (wr_addr_q == touch_pkg::OFS_CTRL);
   wire wr_status = wr_pend_q & (wr_addr_q == touch_pkg::OFS_STATUS);
   wire wr_mc0    = wr_pend_q & (wr_addr_q == touch_pkg::OFS_MODULE_CTRL0);
   wire wr_mc1    = wr_pend_q & (wr_addr_q == touch_pkg::OFS_MODULE_CTRL1);
   wire wr_ps0    = wr_pend_q & (wr_addr_q == touch_pkg::OFS_SLOT_PRESET0);
   wire wr_ps1    = wr_pend_q & (wr_addr_q == touch_pkg::OFS_SLOT_PRESET1);

   wire share      = ctrl_q[touch_pkg::CTRL_SHARE_BIT];
   wire start_lvl  = ctrl_q[touch_pkg::CTRL_START_BIT];
   wire start_rise = start_lvl & ~start_q;

   // Status word assembled once for reads
   wire        slot_flag   = (phase_q == PH_RUN);
   wire [31:0] status_word = {
      {(32 - touch_pkg::ST_CF_OVF_BIT - NM){1'b0}},
      cf_ovf_q,
      func_ovf_q,
      slot_flag
   };

   wire [31:0] slot_word = {16'h0000, stat[1].slot_count, stat[0].slot_count};

   wire [31:0] rd_mux =
      (ofs == touch_pkg::OFS_CTRL)         ? {30'h0, ctrl_q} :
      (ofs == touch_pkg::OFS_STATUS)       ? status_word :
      (ofs == touch_pkg::OFS_MODULE_CTRL0) ? {22'h0, mctrl_q[0]} :
      (ofs == touch_pkg::OFS_MODULE_CTRL1) ? {22'h0, mctrl_q[1]} :
      (ofs == touch_pkg::OFS_SLOT_PRESET0) ? {24'h0, preset_q[0]} :
      (ofs == touch_pkg::OFS_SLOT_PRESET1) ? {24'h0, preset_q[1]} :
      (ofs == touch_pkg::OFS_FUNC_COUNT)   ? {16'h0, func_q} :
      (ofs == touch_pkg::OFS_CF_COUNT0)    ? {16'h0, stat[0].cf_count} :
      (ofs == touch_pkg::OFS_CF_COUNT1)    ? {16'h0, stat[1].cf_count} :
      (ofs == touch_pkg::OFS_SLOT_COUNT)   ? slot_word :
      32'h00000000;

   // Write address phase held for its data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= bus_wr & in_range;
         wr_addr_q <= ofs;
      end
   end

   // Read data stands for the data phase only
   wire rd_take = addr_phase & ~hwrite & in_range;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rd_take ? rd_mux : 32'h00000000;
      end
   end

   assign hrdata    = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q      <= touch_pkg::CTRL_RESET;
         mctrl_q[0]  <= touch_pkg::MODULE_CTRL_RESET;
         mctrl_q[1]  <= touch_pkg::MODULE_CTRL_RESET;
         preset_q[0] <= touch_pkg::SLOT_PRESET_RESET;
         preset_q[1] <= touch_pkg::SLOT_PRESET_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= hwdata[1:0];
         end
         if (wr_mc0) begin
            mctrl_q[0] <= mctrl_field(hwdata);
         end
         if (wr_mc1) begin
            mctrl_q[1] <= mctrl_field(hwdata);
         end
         if (wr_ps0) begin
            preset_q[0] <= hwdata[7:0];
         end
         if (wr_ps1) begin
            preset_q[1] <= hwdata[7:0];
         end
      end
   end

   // System clock divided by four
   wire sys4_tick = (div_q == touch_pkg::SYS_DIV_LAST);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= 2'h0;
      end else begin
         div_q <= div_q + 2'h1;
      end
   end

   // Previous start level for edge detection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_q <= 1'b0;
      end else begin
         start_q <= start_lvl;
      end
   end

   // Oscillator inputs arrive from outside the clock domain
   edge_sync #(.W(NM*NK)) u_key_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (key_osc_in),
      .rise     (key_rise)
   );

   edge_sync #(.W(NM)) u_ref_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (ref_osc_in),
      .rise     (ref_rise)
   );

   // Identical modules; keys 1-4 to module 0, keys 5-8 to module 1
   generate
      for (genvar m = 0; m < NM; m++) begin : g_mod
         assign cfg[m].key_sel = mctrl_q[m][touch_pkg::MC_KEY_SEL_LSB +: 2];
         assign cfg[m].tss     = mctrl_q[m][touch_pkg::MC_TSS_BIT];
         assign cfg[m].roen    = mctrl_q[m][touch_pkg::MC_ROEN_BIT];
         assign cfg[m].koen    = mctrl_q[m][touch_pkg::MC_KOEN_BIT];
         assign cfg[m].key_en  = mctrl_q[m][touch_pkg::MC_KEY_EN_LSB +: NK];

         touch_module u_mod (
            .hclk        (hclk),
            .hresetn     (hresetn),
            .cfg         (cfg[m]),
            .key_rise    (key_rise[m*NK +: NK]),
            .ref_rise    (ref_rise[m]),
            .sys4_tick   (sys4_tick),
            .start_rise  (start_rise),
            .start_lvl   (start_lvl),
            .follow      (share & (m != 0)),
            .lead_ovf    (stat[0].slot_ovf),
            .slot_preset (preset_q[m]),
            .stat        (stat[m])
         );

         // Oscillators gated by enables and by the measurement window
         assign ref_osc_en[m] = stat[m].running & cfg[m].roen;
         assign key_osc_en[m*NK +: NK] =
            {NK{stat[m].running & cfg[m].koen}} & cfg[m].key_en;
         assign key_pad_sel[m*NK +: NK] = cfg[m].key_en;
      end
   endgenerate

   // Modules that take part in the interrupt decision
   wire [NM-1:0] part;
   wire [NM-1:0] run_vec;

   generate
      for (genvar m = 0; m < NM; m++) begin : g_part
         assign part[m]    = cfg[m].koen & (|cfg[m].key_en);
         assign run_vec[m] = stat[m].running;
      end
   endgenerate

   wire [NM-1:0] part_eff = (|part) ? part : {{(NM-1){1'b0}}, 1'b1};
   wire busy = share ? run_vec[0] : |(run_vec & part_eff);
   wire slot_end = busy_q & ~busy & start_lvl & ~start_rise;

   // Measurement-period counter for oscillator calibration
   wire func_inc = stat[0].running & ref_rise[0];
   wire func_ovf = func_inc & (func_q == touch_pkg::COUNT_LAST);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         func_q <= 16'h0000;
      end else if (!start_lvl || start_rise) begin
         func_q <= 16'h0000;
      end else if (func_inc) begin
         func_q <= func_q + 16'h0001;
      end
   end

   // Sticky flags: hardware sets, software writes one to clear
   wire [NM-1:0] cf_ovf_evt;

   generate
      for (genvar m = 0; m < NM; m++) begin : g_ovf
         assign cf_ovf_evt[m] = stat[m].cf_ovf;
      end
   endgenerate

   wire [NM-1:0] cf_clr = {NM{wr_status}} & hwdata[touch_pkg::ST_CF_OVF_BIT +: NM];
   wire func_clr = wr_status & hwdata[touch_pkg::ST_FUNC_OVF_BIT];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cf_ovf_q   <= '0;
         func_ovf_q <= 1'b0;
      end else begin
         cf_ovf_q   <= cf_ovf_evt | (cf_ovf_q & ~cf_clr);
         func_ovf_q <= func_ovf | (func_ovf_q & ~func_clr);
      end
   end

   // Measurement phase; the slot flag stands while running
   always_comb begin
      phase_d = phase_q;
      unique case (phase_q)
         PH_IDLE: begin
            if (start_rise) begin
               phase_d = PH_RUN;
            end
         end
         PH_RUN: begin
            if (!start_lvl) begin
               phase_d = PH_IDLE;
            end else if (slot_end) begin
               phase_d = PH_DONE;
            end
         end
         PH_DONE: begin
            if (!start_lvl) begin
               phase_d = PH_IDLE;
            end
         end
         default: begin
            phase_d = PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_q <= PH_IDLE;
      end else begin
         phase_q <= phase_d;
      end
   end

   // Single touch interrupt one cycle after the period ends
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_q <= 1'b0;
         irq_q  <= 1'b0;
      end else begin
         busy_q <= busy;
         irq_q  <= slot_end;
      end
   end

   assign touch_irq = irq_q;

endmodule

// file: test/touch_scan_asserts.sv
`timescale 1ns/1ps
module touch_scan_asserts (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   input  wire logic        hreadyout,
   input  wire logic        hresp,
   input  wire logic [7:0]  key_osc_en,
   input  wire logic [1:0]  ref_osc_en,
   input  wire logic [7:0]  key_pad_sel,
   input  wire logic        touch_irq
);
   logic       wr_q;
   logic       rd_q;
   logic [7:0] wa_q;
   logic       start_q;
   logic [5:0] m0_q;
   logic [5:0] m1_q;
   wire        take = hsel & hready & htrans[1] & (haddr[31:8] == 24'h0);
   wire        idle = (ref_osc_en == 2'h0) && (key_osc_en == 8'h00);
   wire        on   = (|ref_osc_en) || (|key_osc_en);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         wa_q <= 8'h00;
      end else begin
         wr_q <= take & hwrite;
         rd_q <= take & ~hwrite;
         wa_q <= haddr[7:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         start_q <= 1'b0;
         m0_q    <= 6'h00;
         m1_q    <= 6'h00;
      end else if (wr_q) begin
         if (wa_q == touch_pkg::OFS_CTRL) start_q <= hwdata[0];
         if (wa_q == touch_pkg::OFS_MODULE_CTRL0) m0_q <= hwdata[5:0];
         if (wa_q == touch_pkg::OFS_MODULE_CTRL1) m1_q <= hwdata[5:0];
      end
   end
   property p_okay;
      hreadyout && !hresp;
   endproperty
   property p_rd_idle;
      !rd_q |-> hrdata == 32'h0;
   endproperty
   property p_pad;
      key_pad_sel == {m1_q[3:0], m0_q[3:0]};
   endproperty
   property p_key_en;
      |key_osc_en |-> ((key_osc_en & ~{m1_q[3:0], m0_q[3:0]}) == 8'h00) && (m0_q[4] || m1_q[4]);
   endproperty
   property p_ref_en;
      (ref_osc_en & ~{m1_q[5], m0_q[5]}) == 2'h0;
   endproperty
   property p_start;
      on |-> $past(start_q);
   endproperty
   property p_pulse;
      touch_irq |=> !touch_irq;
   endproperty
   property p_stop;
      touch_irq |-> $past(idle) && start_q;
   endproperty
   property p_hold;
      $fell(ref_osc_en[0]) && start_q |=> !ref_osc_en[0] [*3];
   endproperty
   a_okay:    assert property (p_okay) else $error("bus response not ready or not okay");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read data phase");
   a_pad:     assert property (p_pad) else $error("pad select differs from key enables");
   a_key_en:  assert property (p_key_en) else $error("key oscillator enabled without its bits");
   a_ref_en:  assert property (p_ref_en) else $error("reference oscillator enabled without its bit");
   a_start:   assert property (p_start) else $error("oscillators run without start");
   a_pulse:   assert property (p_pulse) else $error("interrupt longer than one cycle");
   a_stop:    assert property (p_stop) else $error("interrupt while oscillators run");
   a_hold:    assert property (p_hold) else $error("oscillator restarted after end");
   c_irq:   cover property (touch_irq);
   c_both:  cover property (ref_osc_en == 2'h3);
   c_abort: cover property ($fell(ref_osc_en[0]) && !start_q);
endmodule

bind touch_key_scan_control touch_scan_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hrdata, .hreadyout, .hresp, .key_osc_en, .ref_osc_en, .key_pad_sel, .touch_irq);

// file: test/touch_pads.sv
`timescale 1ns/1ps
module touch_pads #(
   parameter int KEY_HALF = 4,
   parameter int REF_HALF = 5
) (
   input  wire logic       hclk,
   input  wire logic [7:0] key_osc_en,
   input  wire logic [1:0] ref_osc_en,
   output logic      [7:0] key_osc_in,
   output logic      [1:0] ref_osc_in
);
   int kcnt = 0;
   int rcnt = 0;
   initial begin
      key_osc_in = 8'h00;
      ref_osc_in = 2'h0;
   end
   // Each key has its own oscillator, bit i is key i+1
   always @(posedge hclk) begin
      kcnt <= (kcnt == KEY_HALF - 1) ? 0 : kcnt + 1;
      rcnt <= (rcnt == REF_HALF - 1) ? 0 : rcnt + 1;
      key_osc_in <= key_osc_en & ((kcnt == 0) ? ~key_osc_in : key_osc_in);
      ref_osc_in <= ref_osc_en & ((rcnt == 0) ? ~ref_osc_in : ref_osc_in);
   end
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [7:0]  key_osc_in;
   logic [1:0]  ref_osc_in;
   logic [7:0]  key_osc_en;
   logic [1:0]  ref_osc_en;
   logic [7:0]  key_pad_sel;
   logic        touch_irq;
   logic [31:0] rd;
   logic [31:0] keep;
   int          mismatches = 0;
   int          cmp_count = 0;
   int          cycles = 0;

   touch_key_scan_control u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hburst(3'h0),
      .hprot(4'h3), .hmastlock(1'b0), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .key_osc_in,
      .ref_osc_in, .key_osc_en, .ref_osc_en, .key_pad_sel, .touch_irq);
   touch_pads u_pads (.hclk, .key_osc_en, .ref_osc_en, .key_osc_in, .ref_osc_in);

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches++;
         conclude();
      end
   end

   task automatic conclude();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] ens();
      return {22'h0, ref_osc_en, key_osc_en};
   endfunction
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic cfg(input logic [31:0] c0, c1, p0, p1, ct);
      bus(1'b1, touch_pkg::OFS_MODULE_CTRL0, c0);
      bus(1'b1, touch_pkg::OFS_MODULE_CTRL1, c1);
      bus(1'b1, touch_pkg::OFS_SLOT_PRESET0, p0);
      bus(1'b1, touch_pkg::OFS_SLOT_PRESET1, p1);
      bus(1'b1, touch_pkg::OFS_CTRL, ct);
      repeat (2) @(posedge hclk);
   endtask
   task automatic halt();
      bus(1'b1, touch_pkg::OFS_CTRL, 32'h0);
      repeat (2) @(posedge hclk);
   endtask
   task automatic wait_irq();
      int i = 0;
      while (touch_irq !== 1'b1 && i < 8000) begin
         @(posedge hclk);
         i++;
      end
      chk({31'h0, touch_irq}, 32'h1);
   endtask

   task automatic t_reset();
      logic [7:0] adr [6];
      adr = '{touch_pkg::OFS_CTRL, touch_pkg::OFS_STATUS, touch_pkg::OFS_MODULE_CTRL0,
              touch_pkg::OFS_SLOT_PRESET0, touch_pkg::OFS_FUNC_COUNT, 8'h40};
      chk({23'h0, touch_irq, key_pad_sel}, 32'h0);
      bus(1'b1, 8'h40, 32'hFFFF_FFFF);
      foreach (adr[i]) begin
         bus(1'b0, adr[i], 32'h0);
         chk(rd, 32'h0);
      end
      bus(1'b1, touch_pkg::OFS_MODULE_CTRL1, 32'hFFFF_FFFF);
      bus(1'b0, touch_pkg::OFS_MODULE_CTRL1, 32'h0);
      chk(rd, 32'h3BF);
      bus(1'b1, touch_pkg::OFS_MODULE_CTRL1, 32'h0);
   endtask
   task automatic t_measure(input logic tss);
      cfg({24'h0, tss, 7'h31}, 32'h0, 32'hFE, 32'h0, 32'h1);
      chk(ens(), 32'h101);
      bus(1'b0, touch_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h1);
      wait_irq();
      chk(ens(), 32'h0);
      bus(1'b0, touch_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, touch_pkg::OFS_SLOT_COUNT, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, touch_pkg::OFS_CF_COUNT0, 32'h0);
      keep = rd;
      chk({31'h0, keep != 32'h0}, 32'h1);
      repeat (20) @(posedge hclk);
      bus(1'b0, touch_pkg::OFS_CF_COUNT0, 32'h0);
      chk(rd, keep);
      bus(1'b0, touch_pkg::OFS_FUNC_COUNT, 32'h0);
      chk({31'h0, rd != 32'h0}, 32'h1);
      halt();
      bus(1'b0, touch_pkg::OFS_CF_COUNT0, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, touch_pkg::OFS_FUNC_COUNT, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, touch_pkg::OFS_SLOT_PRESET0, 32'h0);
      chk(rd, 32'hFE);
   endtask
   task automatic t_share();
      cfg(32'hB1, 32'hB2, 32'hFE, 32'h00, 32'h3);
      chk(ens(), 32'h321);
      wait_irq();
      chk(ens(), 32'h0);
      halt();
   endtask
   task automatic t_all();
      int i = 0;
      cfg(32'hB1, 32'hB2, 32'hFE, 32'hFD, 32'h1);
      while (ref_osc_en[0] !== 1'b0 && i < 8000) begin
         @(posedge hclk);
         i++;
      end
      repeat (4) @(posedge hclk);
      chk({30'h0, ref_osc_en[1], touch_irq}, 32'h2);
      wait_irq();
      chk(ens(), 32'h0);
      halt();
   endtask
   task automatic t_nokoen();
      cfg(32'hA1, 32'h0, 32'hFE, 32'h0, 32'h1);
      chk(ens(), 32'h100);
      halt();
      chk(ens(), 32'h0);
      bus(1'b0, touch_pkg::OFS_SLOT_COUNT, 32'h0);
      chk(rd, 32'hFE);
      bus(1'b0, touch_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, touch_pkg::OFS_CTRL, 32'h1);
      repeat (2) @(posedge hclk);
      wait_irq();
      halt();
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_measure(1'b1);
      t_measure(1'b0);
      t_share();
      t_all();
      t_nokoen();
      conclude();
   end
endmodule
